// [src/bble_exec.sv]
`timescale 1ns/1ps
module bble_exec
    import bble_pkg::*;
(
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             sys_rst_i,
    // instruction stream
    input  wire logic [15:0]      instr_i,
    input  wire logic             instr_valid_i,
    output logic                  instr_ready_o,
    output logic [15:0]           pc_o,
    output logic [7:0]            status_flags_register_o,
    // io space
    output bble_io_req_type       io_req_o,
    input  wire logic [7:0]       io_rdata_i,
    // data memory
    output bble_mem_req_type      mem_req_o,
    input  wire logic [7:0]       dmem_rdata_i,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr
);

    bble_core_type s;
    bble_core_type next_s;

    // ------------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------------
    logic [15:0] ins;
    logic [4:0]  d_idx;
    logic [4:0]  r_idx;
    logic [7:0]  rd_val;
    logic [2:0]  bidx;
    logic        accept;
    logic        is_branch_flag_set;
    logic        is_branch_flag_clear;
    logic        flag_test;
    logic        taken;
    logic [15:0] koff;
    logic        is_io;
    logic        is_lsl;
    logic        is_rol;
    logic        is_grp1;
    logic        is_shr;
    logic        is_swap;
    logic        is_bflag;
    logic        is_bst;
    logic        is_bld;
    logic        is_mov;
    logic        is_register_pair_copy;
    logic        is_ldi;
    logic        is_ldp;
    logic        is_ldd;
    logic        is_load;
    logic [4:0]  ptr_lo;
    logic [15:0] ptr_val;
    logic        ptr_inc;
    logic        ptr_dec;
    logic [15:0] ld_addr;
    logic [15:0] ptr_new;
    logic [2:0]  sh_op;
    logic [7:0]  sh_res;
    logic        sh_c;
    logic        sh_z;
    logic        sh_n;
    logic        sh_v;
    logic        apb_wr;
    logic        apb_setup;
    logic        mapped;

    assign ins      = instr_i;
    assign d_idx    = ins[8:4];
    assign r_idx    = {ins[9], ins[3:0]};
    assign rd_val   = s.regs[d_idx];
    assign bidx     = ins[2:0];
    assign accept   = instr_valid_i && instr_ready_o;
    assign is_branch_flag_set  = (ins[15:10] == 6'b111100);
    assign is_branch_flag_clear  = (ins[15:10] == 6'b111101);
    assign koff     = {{9{ins[9]}}, ins[9:3]};
    assign is_io    = (ins[15:10] == 6'b100110) && !ins[8];
    assign is_lsl   = (ins[15:10] == 6'b000011) && (d_idx == r_idx);
    assign is_rol   = (ins[15:10] == 6'b000111) && (d_idx == r_idx);
    assign is_grp1  = (ins[15:9] == 7'b1001010);
    assign is_shr   = is_grp1 && (ins[3:0] inside {4'h5, 4'h6, 4'h7});
    assign is_swap  = is_grp1 && (ins[3:0] == 4'h2);
    assign is_bflag = (ins[15:8] == 8'h94) && (ins[3:0] == 4'h8);
    assign is_bst   = (ins[15:9] == 7'b1111101) && !ins[3];
    assign is_bld   = (ins[15:9] == 7'b1111100) && !ins[3];
    assign is_mov   = (ins[15:10] == 6'b001011);
    assign is_register_pair_copy  = (ins[15:8] == 8'h01);
    assign is_ldi   = (ins[15:12] == 4'he);
    assign is_ldp   = (ins[15:9] == 7'b1001000)
                      && (ins[3:0] inside {4'h1, 4'h2, 4'h9, 4'ha, 4'hc, 4'hd, 4'he});
    assign is_ldd   = (ins[15:14] == 2'b10) && !ins[12] && !ins[9];
    assign is_load  = is_ldp || is_ldd;

    // flag tested by a conditional branch
    always_comb begin
        if (bidx == BBLE_FLAG_S) begin
            flag_test = s.status_flags_register[BBLE_FLAG_N] ^ s.status_flags_register[BBLE_FLAG_V];
        end else begin
            flag_test = s.status_flags_register[bidx];
        end
    end
    assign taken = is_branch_flag_set ? flag_test : !flag_test;

    // pointer selection and load address
    always_comb begin
        ptr_inc = 1'b0;
        ptr_dec = 1'b0;
        if (is_ldd) begin
            ptr_lo = ins[3] ? BBLE_PTR_Y : BBLE_PTR_Z;
        end else if (ins[3:2] == 2'b11) begin
            ptr_lo = BBLE_PTR_X;
        end else begin
            ptr_lo = ins[3] ? BBLE_PTR_Y : BBLE_PTR_Z;
        end
        if (is_ldp) begin
            ptr_inc = (ins[1:0] == 2'b01);
            ptr_dec = (ins[1:0] == 2'b10);
        end
    end
    assign ptr_val = {s.regs[ptr_lo + 5'h01], s.regs[ptr_lo]};
    assign ptr_new = ptr_dec ? ptr_val - 16'h0001 : ptr_val + 16'h0001;
    // displacement adds unsigned q, pre-decrement uses the lowered pointer
    assign ld_addr = is_ldd ? ptr_val + {10'h000, ins[13], ins[11:10], ins[2:0]}
                   : (ptr_dec ? ptr_new : ptr_val);

    // shift operation select
    always_comb begin
        if (is_lsl) begin
            sh_op = BBLE_SH_LSL;
        end else if (is_rol) begin
            sh_op = BBLE_SH_ROL;
        end else if (ins[3:0] == 4'h6) begin
            sh_op = BBLE_SH_LSR;
        end else if (ins[3:0] == 4'h7) begin
            sh_op = BBLE_SH_ROR;
        end else begin
            sh_op = BBLE_SH_ASR;
        end
    end

    bble_shift_unit u_shift (
        .op_i     (sh_op),
        .value_i  (rd_val),
        .carry_i  (s.status_flags_register[BBLE_FLAG_C]),
        .result_o (sh_res),
        .carry_o  (sh_c),
        .zero_o   (sh_z),
        .neg_o    (sh_n),
        .ovf_o    (sh_v)
    );

    // apb decode
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite;
    assign mapped    = paddr inside {BBLE_REG_CTRL, BBLE_REG_FLAGS, BBLE_REG_PC,
                                     BBLE_REG_RETIRED, BBLE_REG_STATUS};

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s            = s;
        next_s.io_req.rd  = 1'b0;
        next_s.io_req.wr  = 1'b0;
        next_s.mem_req.rd = 1'b0;
        // sticky clear first, so an illegal code in the same cycle sets it again
        if (apb_wr && paddr == BBLE_REG_STATUS && pwdata[0]) begin
            next_s.illegal = 1'b0;
        end
        unique case (s.state)
            BBLE_IDLE: begin
                if (accept) begin
                    next_s.pc      = s.pc + 16'h0001;
                    next_s.retired = s.retired + 32'h0000_0001;
                    if (is_branch_flag_set || is_branch_flag_clear) begin
                        if (taken) begin
                            next_s.pc    = s.pc + koff + 16'h0001;
                            next_s.state = BBLE_BRANCH;
                        end
                    end else if (is_io) begin
                        next_s.io_req.rd   = 1'b1;
                        next_s.io_req.addr = ins[7:3];
                        next_s.io_bit      = bidx;
                        next_s.io_set      = ins[9];
                        next_s.state       = BBLE_IO;
                    end else if (is_lsl || is_rol || is_shr) begin
                        next_s.regs[d_idx]           = sh_res;
                        next_s.status_flags_register[BBLE_FLAG_C]     = sh_c;
                        next_s.status_flags_register[BBLE_FLAG_Z]     = sh_z;
                        next_s.status_flags_register[BBLE_FLAG_N]     = sh_n;
                        next_s.status_flags_register[BBLE_FLAG_V]     = sh_v;
                    end else if (is_swap) begin
                        next_s.regs[d_idx] = {rd_val[3:0], rd_val[7:4]};
                    end else if (is_bflag) begin
                        next_s.status_flags_register[ins[6:4]] = !ins[7];
                    end else if (is_bst) begin
                        next_s.status_flags_register[BBLE_FLAG_T] = rd_val[bidx];
                    end else if (is_bld) begin
                        next_s.regs[d_idx][bidx] = s.status_flags_register[BBLE_FLAG_T];
                    end else if (is_mov) begin
                        next_s.regs[d_idx] = s.regs[r_idx];
                    end else if (is_register_pair_copy) begin
                        next_s.regs[{ins[7:4], 1'b0}] = s.regs[{ins[3:0], 1'b0}];
                        next_s.regs[{ins[7:4], 1'b1}] = s.regs[{ins[3:0], 1'b1}];
                    end else if (is_ldi) begin
                        next_s.regs[{1'b1, ins[7:4]}] = {ins[11:8], ins[3:0]};
                    end else if (is_load) begin
                        next_s.mem_req.rd   = 1'b1;
                        next_s.mem_req.addr = ld_addr;
                        next_s.ld_dest      = d_idx;
                        next_s.state        = BBLE_LOAD;
                        if (ptr_inc || ptr_dec) begin
                            next_s.regs[ptr_lo]          = ptr_new[7:0];
                            next_s.regs[ptr_lo + 5'h01]  = ptr_new[15:8];
                        end
                    end else begin
                        next_s.illegal = 1'b1; // unknown code runs as a no-op
                    end
                end
            end
            BBLE_BRANCH: begin
                next_s.state = BBLE_IDLE; // second cycle of a taken branch
            end
            BBLE_IO: begin
                next_s.io_req.wr    = 1'b1;
                next_s.io_req.wdata = io_rdata_i;
                next_s.io_req.wdata[s.io_bit] = s.io_set;
                next_s.state        = BBLE_IDLE;
            end
            BBLE_LOAD: begin
                next_s.regs[s.ld_dest] = dmem_rdata_i;
                next_s.state           = BBLE_IDLE;
            end
        endcase
        // apb read data captured in the setup phase
        if (apb_setup) begin
            unique case (paddr)
                BBLE_REG_CTRL:    next_s.prdata = {31'h0000_0000, s.run};
                BBLE_REG_FLAGS:   next_s.prdata = {24'h00_0000, s.status_flags_register};
                BBLE_REG_PC:      next_s.prdata = {16'h0000, s.pc};
                BBLE_REG_RETIRED: next_s.prdata = s.retired;
                BBLE_REG_STATUS:  next_s.prdata = {31'h0000_0000, s.illegal};
                default:          next_s.prdata = 32'h0000_0000;
            endcase
        end
        // apb writes win over same-cycle instruction flag updates
        if (apb_wr) begin
            if (paddr == BBLE_REG_CTRL) begin
                next_s.run = pwdata[0];
            end
            if (paddr == BBLE_REG_FLAGS) begin
                next_s.status_flags_register = pwdata[7:0];
            end
        end
        if (sys_rst_i) begin
            next_s         = '0;
            next_s.state   = BBLE_IDLE;
            next_s.run     = BBLE_RUN_RESET;
            next_s.status_flags_register    = BBLE_FLAGS_RESET;
            next_s.pc      = BBLE_PC_RESET;
        end
    end

    // state register
    always_ff @(posedge clock_i) begin
        s <= next_s;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign instr_ready_o           = (s.state == BBLE_IDLE) && s.run && !sys_rst_i;
    assign pc_o                    = s.pc;
    assign status_flags_register_o = s.status_flags_register;
    assign io_req_o                = s.io_req;
    assign mem_req_o               = s.mem_req;
    assign prdata                  = s.prdata;
    assign pready                  = 1'b1;
    assign pslverr                 = psel && penable && !mapped;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_branch_taken: assert property (
        accept && (is_branch_flag_set || is_branch_flag_clear) && taken
        |=> pc_o == $past(s.pc) + $past(koff) + 16'h0001 && !instr_ready_o ##1
            s.state == BBLE_IDLE)
        else $error("taken branch target or timing wrong");

    a_branch_skip: assert property (
        accept && (is_branch_flag_set || is_branch_flag_clear) && !taken
        |=> pc_o == $past(s.pc) + 16'h0001 && s.state == BBLE_IDLE)
        else $error("untaken branch not single cycle");

    a_signed_ge: assert property (
        accept && is_branch_flag_clear && bidx == BBLE_FLAG_S
        && (s.status_flags_register[BBLE_FLAG_N] ^ s.status_flags_register[BBLE_FLAG_V]) == 1'b0
        |=> s.state == BBLE_BRANCH)
        else $error("signed ge branch not taken");

    a_signed_lt: assert property (
        accept && is_branch_flag_set && bidx == BBLE_FLAG_S
        && (s.status_flags_register[BBLE_FLAG_N] ^ s.status_flags_register[BBLE_FLAG_V]) == 1'b0
        |=> pc_o == $past(s.pc) + 16'h0001)
        else $error("signed lt branch taken wrongly");

    a_branch_flags: assert property (
        accept && (is_branch_flag_set || is_branch_flag_clear) && !apb_wr |=> $stable(s.status_flags_register))
        else $error("branch changed a flag");

    a_io_bit: assert property (
        accept && is_io |=> io_req_o.rd ##1
        io_req_o.wr && io_req_o.wdata[$past(bidx, 2)] == $past(ins[9], 2))
        else $error("io bit not forced");

    a_shift_carry: assert property (
        accept && is_shr && !apb_wr
        |=> s.status_flags_register[BBLE_FLAG_C] == $past(rd_val[0]))
        else $error("right shift carry wrong");

    a_left_carry: assert property (
        accept && (is_lsl || is_rol) && !apb_wr
        |=> s.status_flags_register[BBLE_FLAG_C] == $past(rd_val[7]))
        else $error("left shift carry wrong");

    a_bit_store: assert property (
        accept && is_bst && !apb_wr
        |=> s.status_flags_register[BBLE_FLAG_T] == $past(rd_val[bidx])
            && s.status_flags_register[5:0] == $past(s.status_flags_register[5:0]))
        else $error("bit store wrong");

    a_flag_one: assert property (
        accept && is_bflag && !apb_wr
        |=> s.status_flags_register[$past(ins[6:4])] == !$past(ins[7]))
        else $error("flag set or clear wrong");

    a_load_data: assert property (
        accept && is_load |=> mem_req_o.rd && mem_req_o.addr == $past(ld_addr) ##1
        s.regs[$past(d_idx, 2)] == $past(dmem_rdata_i))
        else $error("indirect load wrong");

    a_swap_nib: assert property (
        accept && is_swap |=> s.regs[$past(d_idx)] == {$past(rd_val[3:0]), $past(rd_val[7:4])})
        else $error("nibble swap wrong");

endmodule

// [src/bble_pkg.sv]
package bble_pkg;

    // ------------------------------------------------------------------
    // status flag bit positions
    // ------------------------------------------------------------------
    localparam logic [2:0] BBLE_FLAG_C = 3'h0;
    localparam logic [2:0] BBLE_FLAG_Z = 3'h1;
    localparam logic [2:0] BBLE_FLAG_N = 3'h2;
    localparam logic [2:0] BBLE_FLAG_V = 3'h3;
    localparam logic [2:0] BBLE_FLAG_S = 3'h4;
    localparam logic [2:0] BBLE_FLAG_H = 3'h5;
    localparam logic [2:0] BBLE_FLAG_T = 3'h6;
    localparam logic [2:0] BBLE_FLAG_I = 3'h7;

    // ------------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------------
    localparam logic [11:0] BBLE_REG_CTRL    = 12'h000;
    localparam logic [11:0] BBLE_REG_FLAGS   = 12'h004;
    localparam logic [11:0] BBLE_REG_PC      = 12'h008;
    localparam logic [11:0] BBLE_REG_RETIRED = 12'h00c;
    localparam logic [11:0] BBLE_REG_STATUS  = 12'h010;
    localparam logic        BBLE_RUN_RESET   = 1'h1;
    localparam logic [7:0]  BBLE_FLAGS_RESET = 8'h00;
    localparam logic [15:0] BBLE_PC_RESET    = 16'h0000;

    // ------------------------------------------------------------------
    // pointer register pairs (low byte index)
    // ------------------------------------------------------------------
    localparam logic [4:0] BBLE_PTR_X = 5'h1a;
    localparam logic [4:0] BBLE_PTR_Y = 5'h1c;
    localparam logic [4:0] BBLE_PTR_Z = 5'h1e;

    // ------------------------------------------------------------------
    // shift unit operation codes
    // ------------------------------------------------------------------
    localparam logic [2:0] BBLE_SH_LSL = 3'h0;
    localparam logic [2:0] BBLE_SH_ROL = 3'h1;
    localparam logic [2:0] BBLE_SH_LSR = 3'h2;
    localparam logic [2:0] BBLE_SH_ROR = 3'h3;
    localparam logic [2:0] BBLE_SH_ASR = 3'h4;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        BBLE_IDLE   = 4'b0001,
        BBLE_BRANCH = 4'b0010,
        BBLE_IO     = 4'b0100,
        BBLE_LOAD   = 4'b1000
    } bble_state_type;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } bble_io_req_type;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } bble_mem_req_type;

    typedef struct packed {
        bble_state_type    state;
        logic [31:0][7:0]  regs;
        logic [7:0]        status_flags_register;
        logic [15:0]       pc;
        logic              run;
        logic              illegal;
        logic [31:0]       retired;
        logic [2:0]        io_bit;
        logic              io_set;
        logic [4:0]        ld_dest;
        bble_io_req_type   io_req;
        bble_mem_req_type  mem_req;
        logic [31:0]       prdata;
    } bble_core_type;

endpackage

// [src/bble_shift_unit.sv]
`timescale 1ns/1ps
module bble_shift_unit
    import bble_pkg::*;
(
    // operation
    input  wire logic [2:0] op_i,
    input  wire logic [7:0] value_i,
    input  wire logic       carry_i,
    // result and flags
    output logic [7:0]      result_o,
    output logic            carry_o,
    output logic            zero_o,
    output logic            neg_o,
    output logic            ovf_o
);

    // ------------------------------------------------------------------
    // shift and rotate datapath
    // ------------------------------------------------------------------
    always_comb begin
        result_o = value_i;
        carry_o  = carry_i;
        unique case (op_i)
            BBLE_SH_LSL: begin
                result_o = {value_i[6:0], 1'b0};
                carry_o  = value_i[7];
            end
            BBLE_SH_ROL: begin
                result_o = {value_i[6:0], carry_i};
                carry_o  = value_i[7];
            end
            BBLE_SH_LSR: begin
                result_o = {1'b0, value_i[7:1]};
                carry_o  = value_i[0];
            end
            BBLE_SH_ROR: begin
                result_o = {carry_i, value_i[7:1]};
                carry_o  = value_i[0];
            end
            BBLE_SH_ASR: begin
                result_o = {value_i[7], value_i[7:1]}; // sign bit kept
                carry_o  = value_i[0];
            end
            default: begin
                result_o = value_i;
                carry_o  = carry_i;
            end
        endcase
    end

    // flags from the result and the shifted-out carry
    assign zero_o = (result_o == 8'h00);
    assign neg_o  = result_o[7];
    assign ovf_o  = result_o[7] ^ carry_o;

endmodule

// [verification/bble_far_side.sv]
`timescale 1ns/1ps
module bble_far_side
    import bble_pkg::*;
(
    // core requests
    input  wire logic             clock_i,
    input  wire bble_io_req_type  io_req_i,
    input  wire bble_mem_req_type mem_req_i,
    // answers
    output logic [7:0]            io_rdata_o,
    output logic [7:0]            dmem_rdata_o
);
    logic [31:0][7:0] io_mem;
    logic [7:0]       io_last = 8'h00;
    logic [7:0]       mem_last = 8'h00;

    // io space starts with a known pattern per address
    initial for (int i = 0; i < 32; i++) io_mem[i] = 8'ha5 ^ 8'(i);

    // idle lines show the inverse of the last byte so stale data never matches
    assign io_rdata_o = io_req_i.rd ? io_mem[io_req_i.addr] : ~io_last;
    assign dmem_rdata_o = mem_req_i.rd ? (mem_req_i.addr[7:0] ^ mem_req_i.addr[15:8] ^ 8'h5a)
                                       : ~mem_last;

    // remember last bytes and take io write-backs
    always @(posedge clock_i) begin
        io_last <= io_rdata_o;
        mem_last <= dmem_rdata_o;
        if (io_req_i.wr) io_mem[io_req_i.addr] <= io_req_i.wdata;
    end
endmodule

// [verification/bble_exec_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module bble_exec_tb
    import bble_pkg::*;
;
    logic             clock_i = 1'b0;
    logic             sys_rst_i = 1'b1;
    logic [15:0]      instr_i = 16'h0000;
    logic             instr_valid_i = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0;
    logic             instr_ready_o, pready, pslverr, er, t;
    logic [15:0]      pc_o;
    logic [15:0]      pc_m = 16'h0000;
    logic [7:0]       status_flags_register_o, io_rdata_i, dmem_rdata_i, f;
    logic [6:0]       k;
    logic [31:0]      prdata, rd;
    bble_io_req_type  io_req_o;
    bble_mem_req_type mem_req_o;
    int               errors = 0;
    int               samples_checked = 0;
    logic [15:0]      sh_op [7] = '{16'h0f00, 16'h1f00, 16'h9506, 16'h9507, 16'h9505,
                                    16'h9502, 16'h0f00};
    logic [7:0]       sh_in [7] = '{8'h96, 8'h96, 8'h96, 8'h96, 8'h96, 8'h96, 8'h80};
    logic [7:0]       sh_res [7] = '{8'h2c, 8'h2d, 8'h4b, 8'hcb, 8'hcb, 8'h69, 8'h00};
    logic [7:0]       sh_flg [7] = '{8'h09, 8'h09, 8'h00, 8'h0c, 8'h0c, 8'h01, 8'h0b};

    // 50 MHz core clock
    always #10 clock_i = ~clock_i;

    bble_exec i_bble_exec (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .pc_o(pc_o),
        .status_flags_register_o(status_flags_register_o), .io_req_o(io_req_o),
        .io_rdata_i(io_rdata_i), .mem_req_o(mem_req_o), .dmem_rdata_i(dmem_rdata_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    bble_far_side i_bble_far_side (.clock_i(clock_i), .io_req_i(io_req_o),
        .mem_req_i(mem_req_o), .io_rdata_o(io_rdata_i), .dmem_rdata_o(dmem_rdata_i));

    // ------------------------------------------------------------------
    // bus and instruction drivers
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic guard(input int n);
        if (n >= 20) begin
            errors++;
            end_sim();
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        guard(n);
    endtask

    // offer one word, return just after the accepting edge
    task automatic issue(input logic [15:0] w);
        int n;
        @(posedge clock_i);
        instr_i <= w;
        instr_valid_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (instr_ready_o !== 1'b1 && n < 20);
        instr_valid_i <= 1'b0;
        pc_m = pc_m + 16'h0001;
        guard(n);
        #1;
    endtask

    function automatic logic [15:0] load_constant(input logic [4:0] d, input logic [7:0] v);
        return {4'he, v[7:4], d[3:0], v[3:0]};
    endfunction

    // register value seen through the z pointer address (r31 stays zero)
    task automatic probe(input logic [4:0] r, input logic [7:0] e);
        issue({6'b001011, r[4], 5'h1e, r[3:0]});
        issue(16'h8000);
        `CHK("probe", {1'b1, 8'h00, e}, mem_req_o)
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, BBLE_REG_CTRL, 32'h0);
        `CHK("ctrl", {31'h0, BBLE_RUN_RESET}, rd)
        apb(1'b0, BBLE_REG_PC, 32'h0);
        `CHK("pc", {16'h0, BBLE_PC_RESET}, rd)
        apb(1'b0, 12'h0f0, 32'h0);
        `CHK("unmapped", {1'b1, 32'h0}, {er, rd})
        apb(1'b1, BBLE_REG_CTRL, 32'h0);
        @(posedge clock_i);
        #1;
        `CHK("stall", 1'b0, instr_ready_o)
        apb(1'b1, BBLE_REG_CTRL, 32'h1);
        issue(16'hffff);
        apb(1'b0, BBLE_REG_STATUS, 32'h0);
        `CHK("illegal", 32'h1, rd)
        apb(1'b1, BBLE_REG_STATUS, 32'h1);
        apb(1'b0, BBLE_REG_STATUS, 32'h0);
        `CHK("illclr", 32'h0, rd)
    endtask

    task automatic t_flags();
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, BBLE_REG_FLAGS, 32'h0);
            issue({9'b100101000, 3'(s), 4'h8});
            `CHK("fset", 8'h01 << s, status_flags_register_o)
            apb(1'b1, BBLE_REG_FLAGS, 32'hff);
            issue({9'b100101001, 3'(s), 4'h8});
            `CHK("fclr", ~(8'h01 << s), status_flags_register_o)
        end
    endtask

    task automatic t_branch();
        for (int s = 0; s < 8; s++) for (int v = 0; v < 2; v++) for (int c = 0; c < 2; c++) begin
            f = (s == 4) ? (v ? 8'h04 : 8'h0c) : (v ? 8'h01 << s : ~(8'h01 << s));
            k = v ? 7'h40 : 7'h3f;
            t = ((s == 4) ? f[2] ^ f[3] : f[s]) ^ c[0];
            apb(1'b1, BBLE_REG_FLAGS, {24'h0, f});
            issue({5'b11110, c[0], k, 3'(s)});
            if (t) pc_m = pc_m + {{9{k[6]}}, k};
            `CHK("bpc", pc_m, pc_o)
            `CHK("brdy", ~t, instr_ready_o)
            `CHK("bflg", f, status_flags_register_o)
        end
    endtask

    task automatic t_shift();
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, BBLE_REG_FLAGS, 32'h1);
            issue(load_constant(5'h10, sh_in[i]));
            issue(sh_op[i]);
            `CHK("shflg", sh_flg[i], status_flags_register_o)
            probe(5'h10, sh_res[i]);
        end
    endtask

    task automatic t_tbit();
        apb(1'b1, BBLE_REG_FLAGS, 32'h0);
        issue(load_constant(5'h11, 8'h08));
        issue(16'hfb13);
        `CHK("tset", 8'h40, status_flags_register_o)
        issue(load_constant(5'h12, 8'h81));
        issue(16'hf926);
        `CHK("tkeep", 8'h40, status_flags_register_o)
        probe(5'h12, 8'hc1);
        issue(16'hfa22);
        `CHK("tclr", 8'h00, status_flags_register_o)
    endtask

    task automatic t_io(input logic [15:0] w, input logic [7:0] e);
        issue(w);
        `CHK("iord", {2'b10, w[7:3]}, {io_req_o.rd, io_req_o.wr, io_req_o.addr})
        @(posedge clock_i);
        #1;
        `CHK("iowr", {2'b01, w[7:3], e}, io_req_o)
        `CHK("ioflg", 8'h00, status_flags_register_o)
    endtask

    task automatic t_load();
        issue(load_constant(5'h1a, 8'h10));
        issue(load_constant(5'h1b, 8'h20));
        issue(16'h901d);
        `CHK("ldinc", {1'b1, 16'h2010}, mem_req_o)
        issue(16'h902e);
        `CHK("lddec", {1'b1, 16'h2010}, mem_req_o)
        issue(load_constant(5'h1c, 8'h30));
        issue(16'hac7f);
        `CHK("ldq", {1'b1, 16'h006f}, mem_req_o)
        issue(16'h8048);
        `CHK("ldy", {1'b1, 16'h0030}, mem_req_o)
        probe(5'h01, 8'h6a);
        probe(5'h07, 8'h35);
        `CHK("ldflg", 8'h00, status_flags_register_o)
        issue(16'h01ad);
        probe(5'h14, 8'h10);
        probe(5'h15, 8'h20);
        `CHK("pcend", pc_m, pc_o)
    endtask

    // reset, then every scenario in turn
    initial begin
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_flags();
        t_branch();
        t_shift();
        t_tbit();
        t_io(16'h9a2b, 8'ha8);
        t_io(16'h9835, 8'h83);
        t_load();
        end_sim();
    end
endmodule
